//--- vip_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt block
// Assumes: 32-bit software register port, byte-wide core memory port
// Notes: Two flag and enable pairs feed each vector
package vip_pkg;
   // Vector table geometry
   localparam int VIP_NUM_VEC = 32;
   localparam int VIP_PAIRS_PER_VEC = 2;
   localparam int VIP_NUM_PAIRS = VIP_NUM_VEC * VIP_PAIRS_PER_VEC;
   localparam logic [15:0] VIP_VEC_TOP = 16'hFFFE;
   localparam logic [15:0] VIP_VEC_BOTTOM = 16'hFFC0;
   localparam logic [4:0] VIP_VEC_LAST_USED = 5'h1D;
   // Register byte offsets
   localparam logic [7:0] VIP_OFF_FLAG_LO = 8'h00;
   localparam logic [7:0] VIP_OFF_FLAG_HI = 8'h04;
   localparam logic [7:0] VIP_OFF_EN_LO = 8'h08;
   localparam logic [7:0] VIP_OFF_EN_HI = 8'h0C;
   localparam logic [7:0] VIP_OFF_CTRL = 8'h10;
   localparam logic [7:0] VIP_OFF_STATUS = 8'h14;
   // Field positions
   localparam int VIP_CTRL_GMASK_BIT = 0;
   localparam int VIP_STAT_BUSY_BIT = 8;
   localparam int VIP_STAT_PEND_BIT = 9;
   // Values after reset
   localparam logic VIP_GMASK_RESET = 1'b1;
   localparam logic [31:0] VIP_REG_RESET = 32'h0000_0000;
   // Sequence state of the interrupt entry
   typedef enum logic [3:0] {
      VIP_IDLE = 4'h0,
      VIP_PUSH_PC_LOW = 4'h1,
      VIP_PUSH_PC_HIGH = 4'h2,
      VIP_PUSH_X = 4'h3,
      VIP_PUSH_A = 4'h4,
      VIP_PUSH_COND = 4'h5,
      VIP_MASK = 4'h6,
      VIP_FETCH_HI = 4'h7,
      VIP_FETCH_LO = 4'h8,
      VIP_LOAD = 4'h9
   } vip_state_t;
   // Address of the high byte of a vector
   function automatic logic [15:0] vip_vec_addr(input logic [4:0] num);
      vip_vec_addr = VIP_VEC_TOP - {10'h000, num, 1'b0};
   endfunction
endpackage

//--- vip_req_if.sv
// Purpose: Carries vector requests to the priority picker and its answer back
// Assumes: Purely combinational path within one clock
// Notes: None
`timescale 1ns/100ps
interface vip_req_if;
   logic [vip_pkg::VIP_NUM_VEC-1:0] req;
   logic pending;
   logic [4:0] vec_num;
   modport ctrl (output req, input pending, input vec_num);
   modport prio (input req, output pending, output vec_num);
endinterface

//--- vip_prio.sv
// Purpose: Picks the pending vector with the largest number
// Assumes: Request bits are one per vector
// Notes: Combinational
`timescale 1ns/100ps
module vip_prio
(
   // Request and answer
   vip_req_if.prio p
);
   import vip_pkg::*;

   // Ascending scan so the largest pending number wins
   always_comb
   begin
      p.pending = 1'b0;
      p.vec_num = 5'h00;
      for (int i = 0; i < VIP_NUM_VEC; i++)
      begin
         if (p.req[i])
         begin
            p.pending = 1'b1;
            p.vec_num = 5'(i);
         end
      end
   end
endmodule

//--- vip_ctrl.sv
// Purpose: Vectored interrupt entry with flags, enables and priority
// Assumes: Core signals and event pulses share clk
// Notes: Vector fetch data arrive one cycle after the read strobe
`timescale 1ns/100ps
module vip_ctrl
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Software register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Peripheral event pulses
   input wire logic [vip_pkg::VIP_NUM_PAIRS-1:0] source_event,
   // Core state
   input wire logic instr_done,
   input wire logic [15:0] pc,
   input wire logic [7:0] index_x,
   input wire logic [7:0] accum,
   input wire logic [7:0] condition_code_register,
   input wire logic [15:0] stack_ptr,
   // Core memory port
   output logic mem_write,
   output logic mem_read,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // Core control
   output logic pc_load,
   output logic [15:0] pc_next,
   output logic global_mask,
   output logic irq_req
);
   import vip_pkg::*;

   logic [VIP_NUM_PAIRS-1:0] flag;
   logic [VIP_NUM_PAIRS-1:0] enable;
   vip_state_t st;
   logic [15:0] snap_pc;
   logic [7:0] snap_x;
   logic [7:0] snap_a;
   logic [7:0] snap_cond;
   logic [15:0] snap_sp;
   logic [4:0] vec_sel;
   logic [7:0] vec_hi;
   logic [4:0] last_vec;
   logic accept;
   logic [31:0] next_clear_lo;
   logic [31:0] next_clear_hi;
   vip_req_if rq ();

   vip_prio u_prio
   (
      .p (rq.prio)
   );

   // Requests per vector from its flag and enable pairs
   always_comb
   begin
      for (int v = 0; v < VIP_NUM_VEC; v++)
      begin
         rq.req[v] = |(flag[v*VIP_PAIRS_PER_VEC +: VIP_PAIRS_PER_VEC]
            & enable[v*VIP_PAIRS_PER_VEC +: VIP_PAIRS_PER_VEC]);
      end
   end

   // Write-one-to-clear masks for the flag words
   always_comb
   begin
      next_clear_lo = 32'h0000_0000;
      next_clear_hi = 32'h0000_0000;
      if (reg_write && reg_addr == VIP_OFF_FLAG_LO)
      begin
         next_clear_lo = reg_wdata;
      end
      if (reg_write && reg_addr == VIP_OFF_FLAG_HI)
      begin
         next_clear_hi = reg_wdata;
      end
   end

   // Sticky event flags, a new event beats a clear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flag <= '0;
      end
      else
      begin
         flag <= (flag & ~{next_clear_hi, next_clear_lo}) | source_event;
      end
   end

   // Local enables
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         enable <= '0;
      end
      else if (reg_write && reg_addr == VIP_OFF_EN_LO)
      begin
         enable[31:0] <= reg_wdata;
      end
      else if (reg_write && reg_addr == VIP_OFF_EN_HI)
      begin
         enable[63:32] <= reg_wdata;
      end
   end

   // Request level toward the core
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq_req <= 1'b0;
      end
      else
      begin
         irq_req <= rq.pending;
      end
   end

   // Acceptance at an instruction end with the mask clear
   assign accept = (st == VIP_IDLE) && instr_done && irq_req && !global_mask;

   // Global mask: set after stacking, cleared only by software
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         global_mask <= VIP_GMASK_RESET;
      end
      else if (st == VIP_PUSH_COND)
      begin
         global_mask <= 1'b1;
      end
      else if (st == VIP_IDLE && reg_write && reg_addr == VIP_OFF_CTRL)
      begin
         global_mask <= reg_wdata[VIP_CTRL_GMASK_BIT];
      end
   end

   // Core state captured at acceptance
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         snap_pc <= 16'h0000;
         snap_x <= 8'h00;
         snap_a <= 8'h00;
         snap_cond <= 8'h00;
         snap_sp <= 16'h0000;
      end
      else if (accept)
      begin
         snap_pc <= pc;
         snap_x <= index_x;
         snap_a <= accum;
         snap_cond <= condition_code_register;
         snap_sp <= stack_ptr;
      end
   end

   // Entry sequence and memory port
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st <= VIP_IDLE;
         mem_write <= 1'b0;
         mem_read <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         pc_load <= 1'b0;
         pc_next <= 16'h0000;
         vec_sel <= 5'h00;
         vec_hi <= 8'h00;
         last_vec <= 5'h00;
      end
      else
      begin
         mem_write <= 1'b0;
         mem_read <= 1'b0;
         pc_load <= 1'b0;
         case (st)
            VIP_IDLE:
            begin
               if (accept)
               begin
                  st <= VIP_PUSH_PC_LOW;
               end
            end
            VIP_PUSH_PC_LOW, VIP_PUSH_PC_HIGH, VIP_PUSH_X, VIP_PUSH_A, VIP_PUSH_COND:
            begin
               // Stack order fixed by state order
               mem_write <= 1'b1;
               mem_addr <= snap_sp - {12'h000, st - 4'h1};
               case (st)
                  VIP_PUSH_PC_LOW: mem_wdata <= snap_pc[7:0];
                  VIP_PUSH_PC_HIGH: mem_wdata <= snap_pc[15:8];
                  VIP_PUSH_X: mem_wdata <= snap_x;
                  VIP_PUSH_A: mem_wdata <= snap_a;
                  default: mem_wdata <= snap_cond;
               endcase
               st <= vip_state_t'(st + 4'h1);
            end
            VIP_MASK:
            begin
               // Pick the winner now that stacking and masking are done
               vec_sel <= rq.vec_num;
               mem_read <= 1'b1;
               mem_addr <= vip_vec_addr(rq.vec_num);
               st <= VIP_FETCH_HI;
            end
            VIP_FETCH_HI:
            begin
               mem_read <= 1'b1;
               mem_addr <= vip_vec_addr(vec_sel) + 16'h0001;
               st <= VIP_FETCH_LO;
            end
            VIP_FETCH_LO:
            begin
               vec_hi <= mem_rdata;
               st <= VIP_LOAD;
            end
            VIP_LOAD:
            begin
               pc_next <= {vec_hi, mem_rdata};
               pc_load <= 1'b1;
               last_vec <= vec_sel;
               st <= VIP_IDLE;
            end
            default:
            begin
               st <= VIP_IDLE;
            end
         endcase
      end
   end

   // Register read port, unmapped reads return zero
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reg_rdata <= VIP_REG_RESET;
      end
      else
      begin
         reg_rdata <= VIP_REG_RESET;
         if (reg_read)
         begin
            case (reg_addr)
               VIP_OFF_FLAG_LO: reg_rdata <= flag[31:0];
               VIP_OFF_FLAG_HI: reg_rdata <= flag[63:32];
               VIP_OFF_EN_LO: reg_rdata <= enable[31:0];
               VIP_OFF_EN_HI: reg_rdata <= enable[63:32];
               VIP_OFF_CTRL: reg_rdata <= {31'h0, global_mask};
               VIP_OFF_STATUS: reg_rdata <= {22'h0, rq.pending, st != VIP_IDLE, 3'h0, last_vec};
               default: reg_rdata <= VIP_REG_RESET;
            endcase
         end
      end
   end

   // Checks
   sequence s_stack;
      mem_write && mem_wdata == snap_pc[7:0] ##1 mem_write && mem_wdata == snap_pc[15:8]
      ##1 mem_write && mem_wdata == snap_x ##1 mem_write && mem_wdata == snap_a
      ##1 mem_write && mem_wdata == snap_cond;
   endsequence
   sequence s_fetch;
      mem_read && mem_addr == vip_vec_addr(vec_sel) ##1 mem_read
      && mem_addr == vip_vec_addr(vec_sel) + 16'h0001;
   endsequence

   property p_prio;
      @(posedge clk) disable iff (reset)
      rq.pending |-> rq.req[rq.vec_num] && (rq.req >> rq.vec_num) == 32'h1;
   endproperty
   a_prio: assert property (p_prio) else $error("lower vector won");

   property p_pair_order;
      @(posedge clk) disable iff (reset)
      st == VIP_FETCH_LO ##1 st == VIP_LOAD |=> pc_load && pc_next == {vec_hi, $past(mem_rdata)};
   endproperty
   a_pair_order: assert property (p_pair_order) else $error("vector bytes misordered");

   property p_req;
      @(posedge clk) disable iff (reset)
      irq_req == $past(|(flag & enable) && 1'b1) || $past(reset);
   endproperty
   a_req: assert property (p_req) else $error("request does not follow flag and enable");

   property p_accept;
      @(posedge clk) disable iff (reset)
      st == VIP_IDLE ##1 st == VIP_PUSH_PC_LOW |-> $past(!global_mask && instr_done && irq_req);
   endproperty
   a_accept: assert property (p_accept) else $error("request taken while masked");

   property p_stack;
      @(posedge clk) disable iff (reset)
      st == VIP_PUSH_PC_LOW |=> s_stack ##1 global_mask;
   endproperty
   a_stack: assert property (p_stack) else $error("stack order wrong");

   property p_fetch;
      @(posedge clk) disable iff (reset)
      st == VIP_MASK |=> (vec_sel == $past(rq.vec_num)) and (s_fetch ##2 pc_load);
   endproperty
   a_fetch: assert property (p_fetch) else $error("wrong vector fetched");

   property p_range;
      @(posedge clk) disable iff (reset)
      mem_read |-> mem_addr >= VIP_VEC_BOTTOM && mem_addr <= VIP_VEC_TOP + 16'h0001;
   endproperty
   a_range: assert property (p_range) else $error("vector address out of table");

   property p_mask_held;
      @(posedge clk) disable iff (reset)
      st inside {VIP_MASK, VIP_FETCH_HI, VIP_FETCH_LO, VIP_LOAD} |-> global_mask;
   endproperty
   a_mask_held: assert property (p_mask_held) else $error("mask dropped in entry");

   property p_shared;
      @(posedge clk) disable iff (reset)
      (flag[11] && enable[11]) && !(flag[10] && enable[10]) |-> rq.req[5];
   endproperty
   a_shared: assert property (p_shared) else $error("second pair ignored");
endmodule

//--- vip_core_model.sv
// Purpose: Core memory model answering vector byte fetches
// Assumes: Byte at address a holds a[7:0] xor 5A
// Notes: Data line flips each idle cycle so stale bytes never match
`timescale 1ns/100ps
module vip_core_model
(
   // Clock
   input wire logic clk,
   // Memory port
   input wire logic mem_read,
   input wire logic [15:0] mem_addr,
   output logic [7:0] mem_rdata
);
   initial mem_rdata = 8'h00;
   // Answer one cycle after the read strobe, else invert
   always @(posedge clk)
   begin
      if (mem_read)
      begin
         mem_rdata <= mem_addr[7:0] ^ 8'h5A;
      end
      else
      begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

//--- test_vectored_interrupt_priority.sv
// Purpose: Self-checking bench of the vectored interrupt block
// Assumes: Vectors 0 and 1 keep their enables at 0
// Notes: Watcher compares memory strobes and reads against queued notes
`timescale 1ns/100ps
module test_vectored_interrupt_priority;
   import vip_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic [63:0] source_event = 64'h0;
   logic instr_done = 1'b0;
   logic [15:0] pc = 16'h0;
   logic [15:0] stack_ptr = 16'h0;
   logic [7:0] index_x = 8'h0;
   logic [7:0] accum = 8'h0;
   logic [7:0] cond_codes = 8'h0;
   logic mem_write, mem_read, pc_load, global_mask, irq_req;
   logic [15:0] mem_addr, pc_next;
   logic [7:0] mem_wdata, mem_rdata;
   logic [31:0] q_rd[$];
   logic [31:0] q_mem[$];
   logic [31:0] q_pc[$];
   logic rd_d = 1'b0;
   int n_fail = 0;
   int checked = 0;
   vip_ctrl u_vip_ctrl (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .source_event(source_event), .instr_done(instr_done),
      .pc(pc), .index_x(index_x), .accum(accum), .condition_code_register(cond_codes),
      .stack_ptr(stack_ptr), .mem_write(mem_write), .mem_read(mem_read),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .pc_load(pc_load), .pc_next(pc_next), .global_mask(global_mask), .irq_req(irq_req));
   vip_core_model u_vip_core_model (.clk(clk), .mem_read(mem_read),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   // Clock
   initial
   begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      q_rd.push_back(e);
      @(posedge clk);
      reg_read <= 1'b0;
   endtask
   // Bounded wait for irq_req (sel 0) or pc_load (sel 1)
   task automatic wait_hi(input int n, input bit sel);
      int i;
      for (i = 0; i < n && (sel ? pc_load : irq_req) !== 1'b1; i++)
      begin
         @(posedge clk);
      end
      if (i == n)
      begin
         n_fail++;
         test_done();
      end
   endtask
   // Watcher of design results
   always @(posedge clk) rd_d <= reg_read;
   always @(negedge clk)
   begin
      if (rd_d)
      begin
         chk(reg_rdata, q_rd.size() ? q_rd.pop_front() : 32'hFFFF_FFFF);
      end
      if (mem_write || mem_read)
      begin
         chk({mem_read, 7'h0, mem_addr, mem_read ? 8'h00 : mem_wdata},
            q_mem.size() ? q_mem.pop_front() : 32'hFFFF_FFFF);
      end
      if (mem_read)
      begin
         chk(global_mask, 32'h1);
      end
      if (pc_load)
      begin
         chk({15'h0, global_mask, pc_next},
            q_pc.size() ? q_pc.pop_front() : 32'hFFFF_FFFF);
      end
   end
   // Main sequence
   initial
   begin : main
      int va, vb, w;
      logic [63:0] en;
      logic [15:0] a;
      void'($urandom(15));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(VIP_OFF_CTRL, 32'h1);
      rd(VIP_OFF_FLAG_LO, 32'h0);
      rd(8'h20, 32'h0);
      $display("test reset values done");
      // Flag without its enable, then the other pair of vector 5
      wr(VIP_OFF_EN_LO, 32'h800);
      @(posedge clk);
      source_event <= 64'h400;
      @(posedge clk);
      source_event <= 64'h0;
      repeat (4) @(posedge clk);
      chk(irq_req, 32'h0);
      rd(VIP_OFF_FLAG_LO, 32'h400);
      @(posedge clk);
      source_event <= 64'h800;
      @(posedge clk);
      source_event <= 64'h0;
      wait_hi(8, 1'b0);
      wr(VIP_OFF_FLAG_LO, 32'hC00);
      repeat (3) @(posedge clk);
      chk(irq_req, 32'h0);
      $display("test flags and enables done");
      // Entry sequences with two competing vectors
      for (int k = 0; k < 28; k++)
      begin
         va = (k == 0) ? 29 : 2 + $urandom_range(27);
         vb = (k == 0) ? 2 : 2 + $urandom_range(27);
         w = (va > vb) ? va : vb;
         en = (64'h1 << (2 * va + $urandom_range(1))) | (64'h1 << (2 * vb + $urandom_range(1)));
         wr(VIP_OFF_EN_LO, en[31:0]);
         wr(VIP_OFF_EN_HI, en[63:32]);
         @(posedge clk);
         source_event <= en;
         @(posedge clk);
         source_event <= 64'h0;
         wait_hi(8, 1'b0);
         pc <= 16'($urandom);
         stack_ptr <= 16'($urandom);
         index_x <= 8'($urandom);
         accum <= 8'($urandom);
         cond_codes <= 8'($urandom);
         instr_done <= 1'b1;
         // Masked: nothing may be taken
         repeat (5) @(posedge clk);
         instr_done <= 1'b0;
         wr(VIP_OFF_CTRL, 32'h0);
         repeat ($urandom_range(3)) @(posedge clk);
         a = VIP_VEC_TOP - 16'(2 * w);
         q_mem.push_back({8'h00, stack_ptr, pc[7:0]});
         q_mem.push_back({8'h00, stack_ptr - 16'h1, pc[15:8]});
         q_mem.push_back({8'h00, stack_ptr - 16'h2, index_x});
         q_mem.push_back({8'h00, stack_ptr - 16'h3, accum});
         q_mem.push_back({8'h00, stack_ptr - 16'h4, cond_codes});
         q_mem.push_back({8'h80, a, 8'h00});
         q_mem.push_back({8'h80, a + 16'h1, 8'h00});
         q_pc.push_back({16'h1, a[7:0] ^ 8'h5A, 8'((a + 16'h1) ^ 16'h5A)});
         instr_done <= 1'b1;
         wait_hi(40, 1'b1);
         instr_done <= 1'b0;
         chk(q_mem.size(), 32'h0);
         wr(VIP_OFF_FLAG_LO, 32'hFFFF_FFFF);
         wr(VIP_OFF_FLAG_HI, 32'hFFFF_FFFF);
         wr(VIP_OFF_EN_LO, 32'h0);
         wr(VIP_OFF_EN_HI, 32'h0);
         rd(VIP_OFF_STATUS, 32'(w));
      end
      repeat (3) @(posedge clk);
      $display("test entry sequences done");
      test_done();
   end
endmodule
